// File: hw/lcis_logic_cell.v
// Logic cell: four input selects, four data gates, eight logic functions, output polarity.
// Assumes all sources and configuration ports are synchronous to ref_clk.
`timescale 1ns/1ns
`default_nettype none
`include "lcis_map.vh"

// Function
// - Thirty-six sources reduced to four logic lines.
// - Four lines drive one of eight functions.
// - Combinational gates plus latch and flip-flop modes.
// - Select, gate, function, polarity in that order.
// - All stages reconfigurable while running, no reset.
// - Output goes to peripherals and to pin.
// - Four independent multiplexers, 6-bit codes each.
// - Codes 0-11: pins, cells, comparators, modulator, clock.
// - Codes 12-23: compare, PWM, sync, async serial.
// - Codes 24-35: timer events, clocks, more timer events.
// - One select register per multiplexer.
// - Sources: pins, clocks, peripherals, register bits.
// - Disabled cell outputs logic zero.
module lcis_logic_cell #(
    parameter NUM_SRC = `LCIS_NUM_SRC
) (
    input  wire                       ref_clk,
    input  wire                       reset,
    input  wire [3:0]                 pinRoutedInput,
    input  wire [3:0]                 logicCellOutputs,
    input  wire [1:0]                 comparatorOut,
    input  wire                       signalModulatorOut,
    input  wire                       referenceClockOut,
    input  wire [3:0]                 captureCompareOut,
    input  wire [1:0]                 pwmOut,
    input  wire [3:0]                 syncPortLines,
    input  wire [1:0]                 asyncSerialPortOut,
    input  wire [3:0]                 timerEventsLow,
    input  wire [3:0]                 clockSources,
    input  wire [3:0]                 timerEventsHigh,
    input  wire                       selWrite,
    input  wire [1:0]                 selIndex,
    input  wire [`LCIS_SEL_W-1:0]     selData,
    input  wire [4*`LCIS_GLS_W-1:0]   gateEnables,
    input  wire [3:0]                 gatePolarity,
    input  wire [`LCIS_MODE_W-1:0]    modeSelect,
    input  wire                       outputPolarity,
    input  wire                       cellEnable,
    output reg                        cellOut,
    output reg                        cellPinOut,
    output reg  [4*`LCIS_SEL_W-1:0]   inputSelectCodes
);

    // ****************************************************************
    // Source bus and select registers.
    // ****************************************************************

    // All 36 sources packed in code order; register bits arrive as pins here.
    wire [NUM_SRC-1:0] srcBus;
    assign srcBus = {timerEventsHigh, clockSources, timerEventsLow, asyncSerialPortOut,
                     syncPortLines, pwmOut, captureCompareOut, referenceClockOut,
                     signalModulatorOut, comparatorOut, logicCellOutputs,
                     pinRoutedInput};

    reg  [`LCIS_SEL_W-1:0] inputSelectReg [0:3];  // One code per multiplexer.
    wire [3:0]             muxOut;                // Selected data lines.
    reg  [3:0]             gateOut;               // Gated logic lines.
    reg                    funcOut;               // Function output before polarity.
    reg                    stateReg;              // Storage for latch and flip-flop modes.
    reg                    stateNext;             // Next value of the storage.
    reg                    clkPrevReg;            // Previous gate 1 level for edge detect.
    integer                i;                     // Loop index of the select register process.
    integer                j;                     // Loop index of the gate process, kept apart.

    // Select registers are written one at a time and survive a disabled cell.
    always @(posedge ref_clk) begin
        if (reset) begin
            for (i = 0; i < 4; i = i + 1) begin
                inputSelectReg[i] <= `LCIS_SEL_RST;
            end
        end else if (selWrite) begin
            inputSelectReg[selIndex] <= selData;
        end
    end

    // ****************************************************************
    // Input multiplexers.
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gMux
            lcis_input_mux #(.NUM_SRC(NUM_SRC)) uMux (
                .srcBus  (srcBus),
                .selCode (inputSelectReg[g]),
                .selOut  (muxOut[g])
            );
        end
    endgenerate

    // ****************************************************************
    // Data gates.
    // ****************************************************************

    // Gate: even bits enable inverted input, odd bits true input; OR then polarity.
    function gateEval;
        input [3:0] d;
        input [7:0] en;
        input       pol;
        integer     k;
        reg         acc;
        begin
            acc = 1'b0;
            for (k = 0; k < 4; k = k + 1) begin
                acc = acc | (en[2*k] & ~d[k]) | (en[2*k+1] & d[k]);
            end
            gateEval = acc ^ pol;
        end
    endfunction

    // Each gate sees all four selected lines, after the multiplexers.
    always @* begin
        for (j = 0; j < 4; j = j + 1) begin
            gateOut[j] = gateEval(muxOut, gateEnables[j*8 +: 8], gatePolarity[j]);
        end
    end

    // ****************************************************************
    // Logic function.
    // ****************************************************************

    // Flip-flop modes clock on a rising gate 1 seen in ref_clk; a trade of
    // true asynchronous latching for a single clock domain.
    wire clkRise;
    assign clkRise = gateOut[0] & ~clkPrevReg;

    always @* begin
        funcOut   = 1'b0;
        stateNext = stateReg;
        case (modeSelect)
            `LCIS_MODE_ANDOR: funcOut = (gateOut[0] & gateOut[1]) | (gateOut[2] & gateOut[3]);
            `LCIS_MODE_ORXOR: funcOut = (gateOut[0] | gateOut[1]) ^ (gateOut[2] | gateOut[3]);
            `LCIS_MODE_AND4: funcOut = &gateOut;
            `LCIS_MODE_SRLAT: begin
                if (gateOut[2] | gateOut[3]) begin
                    stateNext = 1'b0;
                end else if (gateOut[0] | gateOut[1]) begin
                    stateNext = 1'b1;
                end
                funcOut = stateNext;
            end
            `LCIS_MODE_DFFSR: begin
                if (gateOut[2]) begin
                    stateNext = 1'b0;
                end else if (gateOut[3]) begin
                    stateNext = 1'b1;
                end else if (clkRise) begin
                    stateNext = gateOut[1];
                end
                funcOut = stateReg;
            end
            `LCIS_MODE_DFFR: begin
                if (gateOut[2]) begin
                    stateNext = 1'b0;
                end else if (clkRise) begin
                    stateNext = gateOut[1] | gateOut[3];
                end
                funcOut = stateReg;
            end
            `LCIS_MODE_JKFF: begin
                if (gateOut[2]) begin
                    stateNext = 1'b0;
                end else if (clkRise) begin
                    stateNext = (gateOut[1] & ~stateReg) | (~gateOut[3] & stateReg);
                end
                funcOut = stateReg;
            end
            `LCIS_MODE_DLATSR: begin
                if (gateOut[2]) begin
                    stateNext = 1'b0;
                end else if (gateOut[3]) begin
                    stateNext = 1'b1;
                end else if (~gateOut[0]) begin
                    stateNext = gateOut[1];
                end
                funcOut = stateNext;
            end
            default: funcOut = 1'b0;
        endcase
    end

    // ****************************************************************
    // Storage, polarity and outputs.
    // ****************************************************************

    // Disabled cell clears storage and drives zero on both output copies.
    always @(posedge ref_clk) begin
        if (reset) begin
            stateReg         <= 1'b0;
            clkPrevReg       <= 1'b0;
            cellOut          <= 1'b0;
            cellPinOut       <= 1'b0;
            inputSelectCodes <= {4*`LCIS_SEL_W{1'b0}};
        end else begin
            clkPrevReg       <= gateOut[0];
            inputSelectCodes <= {inputSelectReg[3], inputSelectReg[2],
                                 inputSelectReg[1], inputSelectReg[0]};
            if (!cellEnable) begin
                stateReg   <= 1'b0;
                cellOut    <= 1'b0;
                cellPinOut <= 1'b0;
            end else begin
                stateReg   <= stateNext;
                cellOut    <= funcOut ^ outputPolarity;
                cellPinOut <= funcOut ^ outputPolarity;
            end
        end
    end

endmodule // lcis_logic_cell
`default_nettype wire

// File: inc/lcis_map.vh
// Constants for the logic cell input select block: select codes, widths, mode codes.
// Assumes inclusion by bare name from any design file that needs them.
`ifndef LCIS_MAP_VH
`define LCIS_MAP_VH

// ****************************************************************
// Select code field and source count.
// ****************************************************************
`define LCIS_SEL_W        6
`define LCIS_NUM_SRC      36
`define LCIS_SEL_RST      6'h00

// ****************************************************************
// Source index groups inside the 36-wide source bus.
// ****************************************************************
`define LCIS_SRC_PIN0     0
`define LCIS_SRC_CELL0    4
`define LCIS_SRC_CMP0     8
`define LCIS_SRC_MOD      10
`define LCIS_SRC_REFCLK   11
`define LCIS_SRC_CCP0     12
`define LCIS_SRC_PWM0     16
`define LCIS_SRC_SYNC0    18
`define LCIS_SRC_ASYNC0   22
`define LCIS_SRC_TIMER0     24
`define LCIS_SRC_CLK0     28
`define LCIS_SRC_TMR3     32

// ****************************************************************
// Gate enable field, mode field and reset values.
// ****************************************************************
`define LCIS_GLS_W        8
`define LCIS_GLS_RST      8'h00
`define LCIS_MODE_W       3
`define LCIS_MODE_RST     3'h0
`define LCIS_MODE_ANDOR   3'h0
`define LCIS_MODE_ORXOR   3'h1
`define LCIS_MODE_AND4    3'h2
`define LCIS_MODE_SRLAT   3'h3
`define LCIS_MODE_DFFSR   3'h4
`define LCIS_MODE_DFFR    3'h5
`define LCIS_MODE_JKFF    3'h6
`define LCIS_MODE_DLATSR  3'h7

`endif

// File: hw/lcis_input_mux.v
// One input multiplexer of the logic cell: picks one of 36 sources by a 6-bit code.
// Assumes the source bus is synchronous to ref_clk and the code is held by the caller.
`timescale 1ns/1ns
`default_nettype none
`include "lcis_map.vh"

module lcis_input_mux #(
    parameter NUM_SRC = `LCIS_NUM_SRC
) (
    input  wire [NUM_SRC-1:0]         srcBus,
    input  wire [`LCIS_SEL_W-1:0]     selCode,
    output reg                        selOut
);

    // ****************************************************************
    // Selection.
    // ****************************************************************

    // Codes past the last source have no signal, so they give a steady zero.
    always @* begin
        selOut = 1'b0;
        if (selCode < NUM_SRC) begin
            selOut = srcBus[selCode];
        end
    end

endmodule // lcis_input_mux
`default_nettype wire

// File: sim/lcis_source_model.sv
// Far-side model: the pins, sibling cells, peripherals and clocks feeding the cell.
// Assumes the bench writes one 36-bit vector, lowest select code at bit 0.
`timescale 1ns/1ns
`default_nettype none
module lcis_source_model (
    input  wire logic [35:0] srcVec,
    output wire logic [3:0]  pinRoutedInput,
    output wire logic [3:0]  logicCellOutputs,
    output wire logic [1:0]  comparatorOut,
    output wire logic        signalModulatorOut,
    output wire logic        referenceClockOut,
    output wire logic [3:0]  captureCompareOut,
    output wire logic [1:0]  pwmOut,
    output wire logic [3:0]  syncPortLines,
    output wire logic [1:0]  asyncSerialPortOut,
    output wire logic [3:0]  timerEventsLow,
    output wire logic [3:0]  clockSources,
    output wire logic [3:0]  timerEventsHigh
);
    // Every source is a plain level, so one slice per peripheral group is enough.
    assign {timerEventsHigh, clockSources, timerEventsLow, asyncSerialPortOut, syncPortLines,
            pwmOut, captureCompareOut, referenceClockOut, signalModulatorOut, comparatorOut,
            logicCellOutputs, pinRoutedInput} = srcVec;
endmodule // lcis_source_model
`default_nettype wire

// File: sim/lcis_logic_cell_monitor.sv
// Checker for the logic cell: select storage, source routing, enable and pin copy.
// Assumes it is bound onto lcis_logic_cell, one clock ref_clk.
`timescale 1ns/1ns
`default_nettype none
module lcis_logic_cell_monitor #(parameter NUM_SRC = 36) (
    input wire logic        ref_clk,
    input wire logic        reset,
    input wire logic [3:0]  pinRoutedInput,
    input wire logic [3:0]  logicCellOutputs,
    input wire logic [1:0]  comparatorOut,
    input wire logic        signalModulatorOut,
    input wire logic        referenceClockOut,
    input wire logic [3:0]  captureCompareOut,
    input wire logic [1:0]  pwmOut,
    input wire logic [3:0]  syncPortLines,
    input wire logic [1:0]  asyncSerialPortOut,
    input wire logic [3:0]  timerEventsLow,
    input wire logic [3:0]  clockSources,
    input wire logic [3:0]  timerEventsHigh,
    input wire logic        selWrite,
    input wire logic [1:0]  selIndex,
    input wire logic [5:0]  selData,
    input wire logic [31:0] gateEnables,
    input wire logic [3:0]  gatePolarity,
    input wire logic [2:0]  modeSelect,
    input wire logic        outputPolarity,
    input wire logic        cellEnable,
    input wire logic        cellOut,
    input wire logic        cellPinOut,
    input wire logic [23:0] inputSelectCodes
);
    default clocking cb @(posedge ref_clk); endclocking
    // The reported code of mux one matches its register unless a write just landed.
    wire [35:0] srcAll = {timerEventsHigh, clockSources, timerEventsLow, asyncSerialPortOut,
        syncPortLines, pwmOut, captureCompareOut, referenceClockOut, signalModulatorOut,
        comparatorOut, logicCellOutputs, pinRoutedInput};
    wire lineOne = (inputSelectCodes[5:0] < NUM_SRC) ? srcAll[inputSelectCodes[5:0]] : 1'b0;
    sequence cfgSteady;
        cellEnable && !reset && gateEnables == 32'h0000_0002 && !$past(selWrite) && !$past(reset);
    endsequence
    sequence wrTaken; selWrite && !reset ##1 !reset; endsequence
    sequence noWr; !selWrite && !reset ##1 !reset; endsequence
    // Each tested config passes gate one, fed by mux one, straight to the function output.
    property pathOk(logic [2:0] m, logic [3:0] p);
        disable iff (reset) cfgSteady ##0 (modeSelect == m && gatePolarity == p)
            |=> cellOut == ($past(lineOne) ^ $past(outputPolarity));
    endproperty
    AST_PIN_COPY: assert property (disable iff (reset) cellPinOut == cellOut)
        else $error("Pin copy differs from internal output.");
    AST_DISABLE: assert property (!cellEnable |=> !cellOut)
        else $error("Disabled cell drove a one.");
    AST_RESET_CLEAR: assert property (reset |=> inputSelectCodes == 24'h0 && !cellOut)
        else $error("Reset left codes or output set.");
    AST_SEL_WRITE: assert property (disable iff (reset) wrTaken |=>
        inputSelectCodes[$past(selIndex, 2)*6 +: 6] == $past(selData, 2))
        else $error("Written select code not reported.");
    AST_CODES_HOLD: assert property (disable iff (reset) noWr |=> $stable(inputSelectCodes))
        else $error("Select codes moved without a write.");
    AST_PATH_AND4: assert property (pathOk(3'h2, 4'he))
        else $error("Four-input AND path wrong.");
    AST_PATH_ORXOR: assert property (pathOk(3'h1, 4'h0))
        else $error("OR-XOR path wrong.");
    AST_PATH_ANDOR: assert property (pathOk(3'h0, 4'h2))
        else $error("AND-OR path wrong.");
endmodule // lcis_logic_cell_monitor
bind lcis_logic_cell lcis_logic_cell_monitor #(.NUM_SRC(NUM_SRC)) u_lcis_logic_cell_monitor (
    .ref_clk, .reset, .pinRoutedInput, .logicCellOutputs, .comparatorOut, .signalModulatorOut,
    .referenceClockOut, .captureCompareOut, .pwmOut, .syncPortLines, .asyncSerialPortOut,
    .timerEventsLow, .clockSources, .timerEventsHigh, .selWrite, .selIndex, .selData,
    .gateEnables, .gatePolarity, .modeSelect, .outputPolarity, .cellEnable, .cellOut,
    .cellPinOut, .inputSelectCodes);
`default_nettype wire

// File: sim/lcis_logic_cell_bench.sv
// Self-checking bench for the logic cell: routing of codes 0 to 39, enable, reset.
// Assumes the source model beside the design and the checker bound onto it.
`timescale 1ns/1ns
`default_nettype none
module lcis_logic_cell_bench;
    // Configs {mode, gate polarity, output polarity}; each passes gate one through.
    localparam logic [7:0] CFG [4] = '{8'h5c, 8'h20, 8'h04, 8'h5d};
    // Storage steps {mode, pins set/reset/data/clock, expected output}.
    localparam logic [7:0] SEQ [22] = '{8'h88, 8'h84, 8'h87, 8'h83, 8'h81, 8'h82, 8'h91,
        8'h98, 8'ha0, 8'hb3, 8'ha8, 8'hc0, 8'hd7, 8'hd5, 8'hd6, 8'h63, 8'h61, 8'h68, 8'h72,
        8'he5, 8'he3, 8'he0};
    logic [31:0] gateEnables = 32'h0000_0002;
    logic        ref_clk = 1'b0, reset = 1'b1, selWrite = 1'b0, chk = 1'b0, cellEnable = 1'b1;
    logic        outputPolarity = 1'b0, cellOut, cellPinOut, signalModulatorOut, referenceClockOut;
    logic [1:0]  selIndex = 2'h0, comparatorOut, pwmOut, asyncSerialPortOut;
    logic [2:0]  modeSelect = 3'h2;
    logic [3:0]  gatePolarity = 4'he, pinRoutedInput, logicCellOutputs, captureCompareOut;
    logic [3:0]  syncPortLines, timerEventsLow, clockSources, timerEventsHigh;
    logic [5:0]  selData = 6'h00;
    logic [23:0] selVec = 24'h0, inputSelectCodes;
    logic [25:0] expQ [$];
    logic [25:0] expV;
    logic [35:0] srcVec = 36'h0;
    int          bad_count = 0, n_tests = 0;
    lcis_source_model u_lcis_source_model (.srcVec, .pinRoutedInput, .logicCellOutputs,
        .comparatorOut, .signalModulatorOut, .referenceClockOut, .captureCompareOut, .pwmOut,
        .syncPortLines, .asyncSerialPortOut, .timerEventsLow, .clockSources, .timerEventsHigh);
    lcis_logic_cell u_lcis_logic_cell (.ref_clk, .reset, .pinRoutedInput, .logicCellOutputs,
        .comparatorOut, .signalModulatorOut, .referenceClockOut, .captureCompareOut, .pwmOut,
        .syncPortLines, .asyncSerialPortOut, .timerEventsLow, .clockSources, .timerEventsHigh,
        .selWrite, .selIndex, .selData, .gateEnables, .gatePolarity, .modeSelect,
        .outputPolarity, .cellEnable, .cellOut, .cellPinOut, .inputSelectCodes);
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    // The run needs about 2000 cycles, so 10000 cycles means a hang.
    initial begin
        #500000;
        bad_count++;
        final_report();
    end
    // Writes all four select registers back to back, highest index first.
    task write_regs(input logic [23:0] v);
        for (int i = 3; i >= 0; i--) begin
            @(posedge ref_clk);
            selWrite <= 1'b1;
            selIndex <= 2'(i);
            selData <= v[i*6 +: 6];
            selVec[i*6 +: 6] = v[i*6 +: 6];
        end
        @(posedge ref_clk);
        selWrite <= 1'b0;
    endtask
    // Drives v on source c and its inverse elsewhere, so a wrong code shows.
    task check_src(input int c, input logic v);
        logic e;
        @(posedge ref_clk);
        e = cellEnable & (((c < 36) ? v : 1'b0) ^ outputPolarity);
        srcVec <= {36{~v}} ^ (36'h1 << c);
        expQ.push_back({selVec, e, e});
        @(posedge ref_clk);
        chk <= 1'b1;
        @(posedge ref_clk);
        chk <= 1'b0;
    endtask
    // One storage step: new mode and pins, then a look two edges later, as
    // the clocked modes need one edge to store and one to register the output.
    task seq_step(input logic [7:0] s);
        @(posedge ref_clk);
        modeSelect <= s[7:5];
        srcVec <= {32'h0, s[4:1]};
        expQ.push_back({selVec, s[0], s[0]});
        repeat (2) @(posedge ref_clk);
        chk <= 1'b1;
        @(posedge ref_clk);
        chk <= 1'b0;
    endtask
    // Takes the oldest note when a result is due, away from the clock edge.
    always @(negedge ref_clk) begin
        if (chk === 1'b1) begin
            expV = expQ.pop_front();
            n_tests++;
            if ({inputSelectCodes, cellOut, cellPinOut} !== expV) begin
                $display("ERROR outputs expected %h seen %h", expV,
                         {inputSelectCodes, cellOut, cellPinOut});
                bad_count++;
            end
        end
    end
    task final_report();
        $display("Checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        void'($urandom(93));
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        for (int m = 0; m < 4; m++) begin
            @(posedge ref_clk);
            {modeSelect, gatePolarity, outputPolarity} <= CFG[m];
            for (int c = 0; c < 40; c++) begin
                write_regs({6'($urandom % 64), 6'($urandom % 64), 6'($urandom % 64), 6'(c)});
                check_src(c, 1'b1);
                check_src(c, 1'b0);
            end
            $display("Test function config %0d done", m);
        end
        @(posedge ref_clk);
        cellEnable <= 1'b0;
        check_src(3, 1'b0);
        $display("Test disable done");
        cellEnable <= 1'b1;
        reset <= 1'b1;
        @(posedge ref_clk);
        reset <= 1'b0;
        selVec = 24'h0;
        check_src(0, 1'b1);
        $display("Test mid-run reset done");
        // Gate n passes line n, and codes 0-3 put pins 0-3 on lines 0-3.
        @(posedge ref_clk);
        {gatePolarity, outputPolarity} <= 5'h00;
        gateEnables <= 32'h8020_0802;
        write_regs({6'h03, 6'h02, 6'h01, 6'h00});
        for (int s = 0; s < 22; s++) begin
            seq_step(SEQ[s]);
        end
        $display("Test sequential modes done");
        final_report();
    end
endmodule // lcis_logic_cell_bench
`default_nettype wire
